// ### src/vrb_pkg.sv
// constants shared by the utility, reset and buffer-control block
package vrb_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] STAT_OFS  = 8'h04;
    localparam logic [7:0] PEND_OFS  = 8'h08;
    localparam logic [7:0] TUNE_OFS  = 8'h0c;
    // control register fields
    localparam int CTRL_INHIBIT  = 0;
    localparam int CTRL_SYSRST   = 1;
    localparam int CTRL_BFAIL_IE = 2;
    localparam int CTRL_PFAIL_IE = 3;
    localparam int CTRL_W        = 4;
    // pending register fields
    localparam int PEND_BFAIL = 0;
    localparam int PEND_PFAIL = 1;
    // reset values
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [9:0] TUNE_RST = 10'h200;
    // tune code width and slot width
    localparam int TUNE_W = 10;
    localparam int SLOT_W = 5;
    // sysclk: 62 ns period at 10 ns core clock, half period rounded down
    localparam int SYSCLK_PERIOD_NS = 62;
    localparam int CLK_PERIOD_NS    = 10;
    localparam int SYSCLK_HALF      = SYSCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    // system controller selection
    typedef enum logic [1:0] {
        SC_AUTO,
        SC_ON,
        SC_OFF,
        SC_BAD
    } vrb_sc_mode_type;
endpackage : vrb_pkg

// ### src/vrb_util_ctl.sv
// utility, reset, system controller and transceiver control logic
// Functional notes
// RULE1 - bus system reset resets vme side, local
// RULE2 - software can drive bus system reset out
// RULE3 - enabled board-fail falling edge raises interrupt
// RULE4 - enabled power-fail falling edge raises interrupt
// RULE5 - board failure drives system fail unless inhibited
// RULE6 - sysclk driven only as system controller
// RULE7 - controller active flag enables clear/sysclk; code has no clear output and gates sysclk by sc_on
// RULE8 - two straps select on, off or auto
// RULE9 - board never asserts both straps together
// RULE10 - modifier buffers point out when master
// RULE11 - data buffers out on master write/slave read
// RULE12 - one low enable for data/address buffers
// RULE13 - address buffers follow data during mblt
// RULE14 - strobe/ack/error/retry drivers enabled when driving
// RULE15 - local reset input resets pci side
// RULE16 - local system reset request asserts local reset
// RULE17 - board asserts power-on reset at power up
// RULE18 - upper half float strap tri-states extension; code applies the strap only in 32-bit pci mode
// RULE19 - manual tune picks external code else internal
// RULE20 - pll reset input holds pll reset
// RULE21 - four active-low pci interrupt outputs
// RULE22 - read slot number and parity pins
// RULE23 - test reset initialises tap asynchronously
// RULE24 - bus error from slave and timeout
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module vrb_util_ctl
    import vrb_pkg::*;
#(
    parameter int SYS_HALF = SYSCLK_HALF  // sysclk half period
) (
    // clock, reset, enable
    input  wire logic               core_clk_in,
    input  wire logic               rst_b_in,
    input  wire logic               ce_in,
    // apb slave
    input  wire logic               psel_in,
    input  wire logic               penable_in,
    input  wire logic               pwrite_in,
    input  wire logic [7:0]         paddr_in,
    input  wire logic [31:0]        pwdata_in,
    output logic      [31:0]        prdata_out,
    output logic                    pready_out,
    output logic                    pslverr_out,
    // reset pins
    input  wire logic               bus_sysreset_in_b_in,
    input  wire logic               local_reset_in_b_in,
    input  wire logic               local_sysreset_request_b_in,
    input  wire logic               power_on_reset_in_b_in,
    input  wire logic               test_reset_b_in,
    output logic                    bus_sysreset_out,
    output logic                    local_reset_out_b_out,
    output logic                    vme_logic_reset_out,
    output logic                    pci_logic_reset_out,
    output logic                    tap_reset_out,
    // fail pins
    input  wire logic               board_fail_sense_b_in,
    input  wire logic               power_fail_sense_b_in,
    input  wire logic               local_board_failure_b_in,
    output logic                    board_fail_out,
    // system controller
    input  wire logic               sys_ctrl_force_on_b_in,
    input  wire logic               sys_ctrl_force_off_b_in,
    output logic                    sys_ctrl_active_out,
    output logic                    sysclk_out,
    // straps and pll
    input  wire logic               pci_mode32_in,
    input  wire logic               upper_half_float_in,
    input  wire logic               pci_ext_drive_in,
    output logic                    pci_ext_oe_b_out,
    input  wire logic               pll_manual_tune_in,
    input  wire logic [TUNE_W-1:0]  pll_tune_ext_in,
    input  wire logic               pll_reset_in_b_in,
    output logic      [TUNE_W-1:0]  pll_tune_out,
    output logic                    pll_reset_out,
    // slot pins
    input  wire logic [SLOT_W-1:0]  slot_number_b_in,
    input  wire logic               slot_parity_b_in,
    // vme engine state (same clock)
    input  wire logic               vme_master_in,
    input  wire logic               master_write_in,
    input  wire logic               slave_read_in,
    input  wire logic               mblt_in,
    input  wire logic               xfer_active_in,
    input  wire logic               as_drive_in,
    input  wire logic               ds_drive_in,
    input  wire logic               ack_drive_in,
    input  wire logic               retry_drive_in,
    input  wire logic               slave_buserr_in,
    input  wire logic               timeout_buserr_in,
    // transceiver control
    output logic                    modifier_buf_dir_out,
    output logic                    data_buf_dir_out,
    output logic                    addr_buf_dir_out,
    output logic                    data_addr_buf_en_b_out,
    output logic                    addr_strobe_drv_en_out,
    output logic                    data_strobe_drv_en_out,
    output logic                    ack_drv_en_out,
    output logic                    buserr_drv_en_out,
    output logic                    retry_drv_en_out,
    // pci interrupts
    input  wire logic [3:0]         pci_irq_src_in,
    output logic      [3:0]         pci_int_b_out
);

    localparam int NSYNC = 14 + SLOT_W + TUNE_W;

    // reset synchroniser, released after two edges
    logic       rst_m;
    logic       rst_n;
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    // every pin input except test_reset_b_in and pci_ext_drive_in passes two flops, parity pin included
    logic [NSYNC-1:0] pin_raw;   // raw pins
    logic [NSYNC-1:0] sync_a;    // first stage, read by second only
    logic [NSYNC-1:0] sync_b;    // usable copy
    assign pin_raw = {bus_sysreset_in_b_in, local_reset_in_b_in,
                      local_sysreset_request_b_in, power_on_reset_in_b_in,
                      board_fail_sense_b_in, power_fail_sense_b_in,
                      local_board_failure_b_in, sys_ctrl_force_on_b_in,
                      sys_ctrl_force_off_b_in, pci_mode32_in,
                      upper_half_float_in, pll_manual_tune_in,
                      pll_reset_in_b_in, slot_parity_b_in, slot_number_b_in, pll_tune_ext_in};

    for (genvar gi = 0; gi < NSYNC; gi++) begin : g_sync
        // idle level of each pin is one so resets read as negated
        always_ff @(posedge core_clk_in or negedge rst_n) begin
            if (!rst_n) begin
                sync_a[gi] <= 1'b1;
                sync_b[gi] <= 1'b1;
            end else if (ce_in) begin
                sync_a[gi] <= pin_raw[gi];
                sync_b[gi] <= sync_a[gi];
            end
        end
    end

    // unpacked synchronised pins, made active high except fail sense, slot and parity levels
    wire logic              s_sysrst  = ~sync_b[NSYNC-1];  // bus system reset
    wire logic              s_lrst    = ~sync_b[NSYNC-2];  // local reset in
    wire logic              s_lsreq   = ~sync_b[NSYNC-3];  // local system reset request
    wire logic              s_por     = ~sync_b[NSYNC-4];  // power-on reset
    wire logic              s_bfail_n = sync_b[NSYNC-5];   // board fail sense level
    wire logic              s_pfail_n = sync_b[NSYNC-6];   // power fail sense level
    wire logic              s_lbf     = ~sync_b[NSYNC-7];  // local board failure
    wire logic              s_son     = ~sync_b[NSYNC-8];  // force on strap
    wire logic              s_soff    = ~sync_b[NSYNC-9];  // force off strap
    wire logic              s_m32     = sync_b[NSYNC-10];  // 32-bit pci mode
    wire logic              s_float   = sync_b[NSYNC-11];  // upper half float strap
    wire logic              s_manual  = sync_b[NSYNC-12];  // manual tune
    wire logic              s_pllrst  = ~sync_b[NSYNC-13]; // pll reset
    wire logic              s_par_n   = sync_b[NSYNC-14];  // slot parity pin level
    wire logic [SLOT_W-1:0] s_slot_n  = sync_b[TUNE_W +: SLOT_W]; // slot number pins
    wire logic [TUNE_W-1:0] s_tune    = sync_b[TUNE_W-1:0]; // external tune code

    // software state
    logic [CTRL_W-1:0] ctrl;       // control bits
    logic [1:0]        pend;       // sticky fail events
    logic [TUNE_W-1:0] tune_int;   // internal tune code
    logic              bfail_d;    // last board fail level
    logic              pfail_d;    // last power fail level
    vrb_sc_mode_type   sc_mode;    // strap decode
    logic              sc_on;      // controller enable
    // falling edges seen, write access phase, unmapped address
    wire logic         bfail_ev = ce_in & bfail_d & ~s_bfail_n;           // [RULE3]
    wire logic         pfail_ev = ce_in & pfail_d & ~s_pfail_n;           // [RULE4]
    wire logic         wr_acc   = psel_in & penable_in & pwrite_in;
    wire logic         bad_addr = !(paddr_in inside {CTRL_OFS, STAT_OFS, PEND_OFS, TUNE_OFS});

    // strap decode; both asserted is undefined and kept off
    always_comb begin
        case ({s_son, s_soff})
            2'b10:   sc_mode = SC_ON;                                     // [RULE8]
            2'b01:   sc_mode = SC_OFF;                                    // [RULE8]
            2'b00:   sc_mode = SC_AUTO;                                   // [RULE8]
            default: sc_mode = SC_BAD;                                    // [RULE9]
        endcase
    end

    // auto mode: the board in slot one is controller
    always_comb begin
        case (sc_mode)
            SC_ON:   sc_on = 1'b1;
            SC_AUTO: sc_on = (~s_slot_n == SLOT_W'(1));
            default: sc_on = 1'b0;
        endcase
    end

    // control and tune registers
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl     <= CTRL_RST;
            tune_int <= TUNE_RST;
        end else if (ce_in && wr_acc) begin
            if (paddr_in == CTRL_OFS) begin
                ctrl <= pwdata_in[CTRL_W-1:0];
            end
            if (paddr_in == TUNE_OFS) begin
                tune_int <= pwdata_in[TUNE_W-1:0];
            end
        end
    end

    // fail edges set sticky flags; write one clears, set wins
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            bfail_d <= 1'b1;
            pfail_d <= 1'b1;
            pend    <= 2'b00;
        end else if (ce_in) begin
            bfail_d <= s_bfail_n;
            pfail_d <= s_pfail_n;
            if (wr_acc && paddr_in == PEND_OFS) begin
                pend <= pend & ~pwdata_in[PEND_PFAIL:PEND_BFAIL];
            end
            if (bfail_ev && ctrl[CTRL_BFAIL_IE]) begin
                pend[PEND_BFAIL] <= 1'b1;                                 // [RULE3]
            end
            if (pfail_ev && ctrl[CTRL_PFAIL_IE]) begin
                pend[PEND_PFAIL] <= 1'b1;                                 // [RULE4]
            end
        end
    end

    // apb answer: zero wait, unmapped gives error and zero data
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            prdata_out  <= 32'h0;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else if (ce_in) begin
            pready_out  <= psel_in & ~penable_in;
            pslverr_out <= psel_in & ~penable_in & bad_addr;
            prdata_out  <= 32'h0;
            if (psel_in && !penable_in && !pwrite_in) begin
                case (paddr_in)
                    CTRL_OFS: prdata_out <= {28'h0, ctrl};
                    STAT_OFS: prdata_out <= {20'h0, ^{s_slot_n, s_par_n},   // [RULE22]
                                             ~s_slot_n, sc_on, s_bfail_n,
                                             s_pfail_n, s_m32, s_manual, s_por};
                    PEND_OFS: prdata_out <= {30'h0, pend};
                    TUNE_OFS: prdata_out <= {22'h0, tune_int};
                    default:  prdata_out <= 32'h0;
                endcase
            end
        end
    end

    // reset outputs
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            bus_sysreset_out      <= 1'b0;
            local_reset_out_b_out <= 1'b0;
            vme_logic_reset_out   <= 1'b1;
            pci_logic_reset_out   <= 1'b1;
            pll_reset_out         <= 1'b1;
        end else if (ce_in) begin
            bus_sysreset_out      <= ctrl[CTRL_SYSRST] | s_lsreq;         // [RULE2]
            local_reset_out_b_out <= ~(s_sysrst | s_lsreq | s_por);       // [RULE1] [RULE16]
            vme_logic_reset_out   <= s_sysrst | s_por;                    // [RULE1]
            pci_logic_reset_out   <= s_lrst | s_por;                      // [RULE15]
            pll_reset_out         <= s_pllrst;                            // [RULE20]
        end
    end

    // tap reset: set at once by the test reset, released on clock
    always_ff @(posedge core_clk_in or negedge test_reset_b_in) begin
        if (!test_reset_b_in) begin
            tap_reset_out <= 1'b1;                                        // [RULE23]
        end else if (ce_in) begin
            tap_reset_out <= 1'b0;
        end
    end

    // system controller and sysclk divider
    logic [7:0] sys_cnt;   // half period counter
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sys_ctrl_active_out <= 1'b0;
            sysclk_out          <= 1'b0;
            sys_cnt             <= 8'h0;
        end else if (ce_in) begin
            sys_ctrl_active_out <= sc_on;                                 // [RULE7]
            if (!sc_on) begin
                sysclk_out <= 1'b0;                                       // [RULE6]
                sys_cnt    <= 8'h0;
            end else if (sys_cnt == 8'(SYS_HALF - 1)) begin
                sysclk_out <= ~sysclk_out;                                // [RULE6]
                sys_cnt    <= 8'h0;
            end else begin
                sys_cnt <= sys_cnt + 8'h1;
            end
        end
    end

    // system fail, pll tune and pci extension enable
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            board_fail_out   <= 1'b0;
            pll_tune_out     <= TUNE_RST;
            pci_ext_oe_b_out <= 1'b1;
        end else if (ce_in) begin
            board_fail_out   <= s_lbf & ~ctrl[CTRL_INHIBIT];              // [RULE5]
            pll_tune_out     <= s_manual ? s_tune : tune_int;             // [RULE19]
            pci_ext_oe_b_out <= s_m32 ? s_float : ~pci_ext_drive_in;      // [RULE18]
        end
    end

    // pci interrupts: line a also carries the fail events
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pci_int_b_out <= 4'hf;
        end else if (ce_in) begin
            pci_int_b_out <= ~(pci_irq_src_in | {3'h0, |pend});           // [RULE21]
        end
    end

    // transceivers; everything released while the vme side is reset
    wire logic dbuf_next = (vme_master_in & master_write_in) | slave_read_in;   // data direction outward
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            modifier_buf_dir_out   <= 1'b0;
            data_buf_dir_out       <= 1'b0;
            addr_buf_dir_out       <= 1'b0;
            data_addr_buf_en_b_out <= 1'b1;
        end else if (ce_in) begin
            modifier_buf_dir_out   <= vme_master_in & ~vme_logic_reset_out;   // [RULE10]
            data_buf_dir_out       <= dbuf_next & ~vme_logic_reset_out;       // [RULE11]
            addr_buf_dir_out       <= (mblt_in ? dbuf_next : vme_master_in) & ~vme_logic_reset_out; // [RULE13]
            data_addr_buf_en_b_out <= ~xfer_active_in | vme_logic_reset_out;  // [RULE12]
        end
    end

    // line driver enables
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            addr_strobe_drv_en_out <= 1'b0;
            data_strobe_drv_en_out <= 1'b0;
            ack_drv_en_out         <= 1'b0;
            buserr_drv_en_out      <= 1'b0;
            retry_drv_en_out       <= 1'b0;
        end else if (ce_in) begin
            addr_strobe_drv_en_out <= as_drive_in & ~vme_logic_reset_out;     // [RULE14]
            data_strobe_drv_en_out <= ds_drive_in & ~vme_logic_reset_out;     // [RULE14]
            ack_drv_en_out         <= ack_drive_in & ~vme_logic_reset_out;    // [RULE14]
            buserr_drv_en_out      <= (slave_buserr_in | timeout_buserr_in)
                                      & ~vme_logic_reset_out;                 // [RULE24]
            retry_drv_en_out       <= retry_drive_in & ~vme_logic_reset_out;  // [RULE14]
        end
    end

    // checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n);

    fail_edge_sets_a: assert property (ce_in && bfail_ev && ctrl[CTRL_BFAIL_IE]
        |=> pend[PEND_BFAIL] ##1 !pci_int_b_out[0]) // [RULE3]
        else $error("board fail edge not flagged");
    power_edge_sets_a: assert property (ce_in && pfail_ev && ctrl[CTRL_PFAIL_IE]
        |=> pend[PEND_PFAIL]) // [RULE4]
        else $error("power fail edge not flagged");
    sysfail_inhibit_a: assert property (ce_in && ctrl[CTRL_INHIBIT]
        |=> !board_fail_out) // [RULE5]
        else $error("system fail driven while inhibited");
    sysclk_gated_a: assert property (!sys_ctrl_active_out && !$past(sc_on)
        |-> !sysclk_out) // [RULE6]
        else $error("sysclk runs without controller");
    strap_on_a: assert property (ce_in && s_son && !s_soff
        |=> sys_ctrl_active_out) // [RULE8]
        else $error("force on strap ignored");
    local_reset_a: assert property (ce_in && s_sysrst
        |=> !local_reset_out_b_out && vme_logic_reset_out) // [RULE1]
        else $error("bus reset not passed to local reset");
    mblt_dir_a: assert property (ce_in && !vme_logic_reset_out && mblt_in
        |=> addr_buf_dir_out == data_buf_dir_out) // [RULE13]
        else $error("address buffers not following data");
    buserr_src_a: assert property (ce_in && !vme_logic_reset_out && timeout_buserr_in
        |=> buserr_drv_en_out) // [RULE24]
        else $error("timeout bus error not driven");
    float_tristate_a: assert property (ce_in && s_m32 && s_float
        |=> pci_ext_oe_b_out) // [RULE18]
        else $error("extension driven while floated");

    both_fail_c: cover property (pend == 2'b11);
    sysclk_run_c: cover property (sys_ctrl_active_out ##1 $rose(sysclk_out));
    sysreset_c: cover property ($rose(bus_sysreset_out));

endmodule : vrb_util_ctl

// ### testbench/vrb_board_model.sv
// board and backplane straps seen by the utility block
`timescale 1ns/1ps
module vrb_board_model
    import vrb_pkg::*;
(
    // clock and requested strap state
    input  wire logic            clk_in,
    input  vrb_sc_mode_type      mode_in,
    input  wire logic [4:0]      slot_in,
    // strap and backplane pins, low active
    output logic                 force_on_b_out,
    output logic                 force_off_b_out,
    output logic                 por_b_out,
    output logic [4:0]           slot_b_out,
    output logic                 parity_b_out
);
    // power-on reset held low for the first cycles
    initial begin
        por_b_out = 1'b0;
        repeat (20) @(posedge clk_in);
        por_b_out <= 1'b1;
    end
    // never both straps low, a bad mode maps to both open
    assign force_on_b_out  = !(mode_in == SC_ON);
    assign force_off_b_out = !(mode_in == SC_OFF);
    // grounded pins read low, parity pin driven as the xor of the slot number
    assign slot_b_out   = ~slot_in;
    assign parity_b_out = ^slot_in;
endmodule : vrb_board_model

// ### testbench/tb_top.sv
// self-checking bench for the utility and reset block
`timescale 1ns/1ps
module tb_top;
    import vrb_pkg::*;
    logic core_clk_in, rst_b_in, ce_in, psel_in, penable_in, pwrite_in;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic pready_out, pslverr_out, er, bus_sysreset_in_b_in, local_reset_in_b_in, local_sysreset_request_b_in;
    logic power_on_reset_in_b_in, test_reset_b_in, bus_sysreset_out, local_reset_out_b_out, vme_logic_reset_out;
    logic pci_logic_reset_out, tap_reset_out, board_fail_sense_b_in, power_fail_sense_b_in, local_board_failure_b_in;
    logic board_fail_out, sys_ctrl_force_on_b_in, sys_ctrl_force_off_b_in, sys_ctrl_active_out, sysclk_out;
    logic pci_mode32_in, upper_half_float_in, pci_ext_drive_in, pci_ext_oe_b_out, pll_manual_tune_in;
    logic pll_reset_in_b_in, pll_reset_out, slot_parity_b_in, vme_master_in, master_write_in, slave_read_in, mblt_in;
    logic xfer_active_in, as_drive_in, ds_drive_in, ack_drive_in, retry_drive_in, slave_buserr_in, timeout_buserr_in;
    logic modifier_buf_dir_out, data_buf_dir_out, addr_buf_dir_out, data_addr_buf_en_b_out, addr_strobe_drv_en_out;
    logic data_strobe_drv_en_out, ack_drv_en_out, buserr_drv_en_out, retry_drv_en_out;
    logic [9:0] pll_tune_ext_in, pll_tune_out;
    logic [4:0] slot_number_b_in, sl;
    logic [3:0] pci_irq_src_in, pci_int_b_out;
    vrb_sc_mode_type md;
    int errors, total_checks, n;
    // design with the shortest safe system clock
    vrb_util_ctl #(.SYS_HALF(1)) dut_u (.*);
    vrb_board_model brd_u (.clk_in(core_clk_in), .mode_in(md), .slot_in(sl), .force_on_b_out(sys_ctrl_force_on_b_in),
        .force_off_b_out(sys_ctrl_force_off_b_in), .por_b_out(power_on_reset_in_b_in),
        .slot_b_out(slot_number_b_in), .parity_b_out(slot_parity_b_in));
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    task wrap_up;
        if (errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    task chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // settle k edges, then look at the falling edge
    task wt(input int k);
        repeat (k) @(posedge core_clk_in);
        @(negedge core_clk_in);
    endtask : wt
    // apb transfer: setup, then access held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int c;
        @(posedge core_clk_in);
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        c = 0;
        do begin @(posedge core_clk_in); c++; end while (pready_out !== 1'b1 && c < 20);
        if (c >= 20) begin errors++; wrap_up; end
        rd = prdata_out;
        er = pslverr_out;
        {psel_in, penable_in} <= 2'b00;
    endtask : apb
    initial begin
        {rst_b_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, pll_manual_tune_in} = '0;
        {vme_master_in, master_write_in, slave_read_in, mblt_in, xfer_active_in, as_drive_in, ds_drive_in} = '0;
        {ack_drive_in, retry_drive_in, slave_buserr_in, timeout_buserr_in, pci_irq_src_in, pci_ext_drive_in} = '0;
        {ce_in, bus_sysreset_in_b_in, local_reset_in_b_in, local_sysreset_request_b_in, test_reset_b_in} = '1;
        {board_fail_sense_b_in, power_fail_sense_b_in, local_board_failure_b_in, pll_reset_in_b_in} = '1;
        {pci_mode32_in, upper_half_float_in, pll_tune_ext_in, sl} = {2'b10, 10'h155, 5'h01};
        md = SC_OFF;
        errors = 0;
        total_checks = 0;
        repeat (16) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        wt(30);
        apb(0, CTRL_OFS, 0); chk(rd, 0);
        apb(0, TUNE_OFS, 0); chk(rd, 32'h200); chk(pll_tune_out, 10'h200);
        apb(0, 8'h10, 0); chk({er, rd}, {1'b1, 32'h0});
        @(posedge core_clk_in) pll_manual_tune_in <= 1; wt(6); chk(pll_tune_out, 10'h155);
        @(posedge core_clk_in) pll_manual_tune_in <= 0; apb(1, TUNE_OFS, 32'h0ab); wt(6);
        chk(pll_tune_out, 10'h0ab);
        @(posedge core_clk_in) pll_reset_in_b_in <= 0; wt(6); chk(pll_reset_out, 1);
        @(posedge core_clk_in) pll_reset_in_b_in <= 1; wt(6); chk(pll_reset_out, 0);
        apb(1, CTRL_OFS, 32'h2); wt(3); chk(bus_sysreset_out, 1);
        apb(1, CTRL_OFS, 32'h0); wt(3); chk(bus_sysreset_out, 0);
        @(posedge core_clk_in) local_sysreset_request_b_in <= 0; wt(6); chk(local_reset_out_b_out, 0);
        @(posedge core_clk_in) local_sysreset_request_b_in <= 1; wt(6); chk(local_reset_out_b_out, 1);
        @(posedge core_clk_in) bus_sysreset_in_b_in <= 0; wt(6);
        chk({local_reset_out_b_out, vme_logic_reset_out}, 2'b01);
        @(posedge core_clk_in) {bus_sysreset_in_b_in, local_reset_in_b_in} <= 2'b10; wt(6);
        chk(pci_logic_reset_out, 1);
        @(posedge core_clk_in) {local_reset_in_b_in, test_reset_b_in} <= 2'b10; wt(0);
        chk(tap_reset_out, 1);
        @(posedge core_clk_in) {test_reset_b_in, local_board_failure_b_in} <= 2'b10; wt(6);
        chk(board_fail_out, 1);
        apb(1, CTRL_OFS, 32'h1); wt(6); chk(board_fail_out, 0);
        for (int i = 0; i < 2; i++) begin
            apb(1, CTRL_OFS, 0);
            @(posedge core_clk_in) {power_fail_sense_b_in, board_fail_sense_b_in} <= ~(2'b01 << i); wt(8);
            apb(0, PEND_OFS, 0); chk(rd, 0);
            @(posedge core_clk_in) {power_fail_sense_b_in, board_fail_sense_b_in} <= 2'b11;
            apb(1, CTRL_OFS, 32'h4 << i);
            @(posedge core_clk_in) {power_fail_sense_b_in, board_fail_sense_b_in} <= ~(2'b01 << i); wt(8);
            apb(0, PEND_OFS, 0); chk({rd, pci_int_b_out[0]}, {32'h1 << i, 1'b0});
            apb(1, PEND_OFS, 32'h1 << i); wt(2);
            apb(0, PEND_OFS, 0); chk({rd, pci_int_b_out[0]}, {32'h0, 1'b1});
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk_in) md <= (i == 0) ? SC_ON : (i == 1) ? SC_OFF : SC_AUTO;
            sl <= 5'(1 + (i == 3));
            wt(8);
            n = 0;
            repeat (8) begin @(negedge core_clk_in); n += sysclk_out; end
            chk({sys_ctrl_active_out, n != 0}, {2{i % 2 == 0}});
        end
        apb(0, STAT_OFS, 0); chk(rd[11:6], 6'h22);
        @(posedge core_clk_in) {vme_master_in, master_write_in, xfer_active_in, mblt_in, as_drive_in} <= '1;
        {ds_drive_in, timeout_buserr_in, pci_irq_src_in} <= {2'b11, 4'ha}; wt(2);
        chk({modifier_buf_dir_out, data_buf_dir_out, addr_buf_dir_out}, 3'h7);
        chk({data_addr_buf_en_b_out, addr_strobe_drv_en_out, data_strobe_drv_en_out}, 3'h3);
        chk({buserr_drv_en_out, ack_drv_en_out, pci_int_b_out}, 6'h25);
        @(posedge core_clk_in) {vme_master_in, master_write_in, timeout_buserr_in} <= '0;
        {slave_read_in, ack_drive_in, retry_drive_in, slave_buserr_in} <= '1; wt(2);
        chk({modifier_buf_dir_out, data_buf_dir_out, addr_buf_dir_out}, 3'h3);
        chk({ack_drv_en_out, retry_drv_en_out, buserr_drv_en_out}, 3'h7);
        @(posedge core_clk_in) {pci_ext_drive_in, upper_half_float_in} <= 2'b10; wt(6);
        chk(pci_ext_oe_b_out, 0);
        @(posedge core_clk_in) upper_half_float_in <= 1; wt(6); chk(pci_ext_oe_b_out, 1);
        wrap_up;
    end
endmodule : tb_top
